// ### jtl_chk.sv
module jtl_chk (
   input wire logic CLK,
   input wire logic RST,
   input wire logic instr_valid,
   input wire logic [31:0] instr,
   input wire logic [31:0] instr_pc,
   input wire logic [31:0] src_value,
   input wire logic redirect,
   input wire logic [31:0] target,
   input wire logic [1:0] instruction_set_select,
   input wire logic fetch_addr_error,
   input wire logic link_we,
   input wire logic [4:0] link_sel,
   input wire logic [31:0] link_value,
   input wire logic busy
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   logic [31:0] j_r;
   logic [31:0] s_r;
   wire take = instr_valid && !busy;
   wire [3:0] slot_hi = instr_pc[31:28];
   // Jump word and source kept from the take edge
   always_ff @(posedge CLK)
   begin
      if (take)
      begin
         j_r <= instr;
         s_r <= src_value;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Every jump form, register forms only with the default hint
   sequence s_jump_taken;
      take && (instr[31:27] == 5'h01
         || (instr[31:26] == 6'h00 && instr[5:1] == 5'h04 && instr[10:6] == 5'h00));
   endsequence
   sequence s_slot;
      instr_valid && busy;
   endsequence
   property p_wait_slot;
      s_jump_taken |=> busy && !redirect;
   endproperty
   a_wait_slot: assert property (p_wait_slot) else $error("no slot wait");
   property p_slot_redirect;
      s_slot |=> redirect && !busy ##1 !redirect;
   endproperty
   a_slot_redirect: assert property (p_slot_redirect) else $error("bad redirect");
   property p_link_value;
      link_we |-> link_value == $past(instr_pc) + 32'h0000_0008;
   endproperty
   a_link_value: assert property (p_link_value) else $error("bad link value");
   property p_region_link;
      link_we && $past(instr[31:26]) == jtl_pkg::OP_REGION_LINK |-> link_sel == 5'h1F;
   endproperty
   a_region_link: assert property (p_region_link) else $error("bad link reg");
   property p_region_target;
      redirect && j_r[31:27] == 5'h01 |->
         target == {$past(slot_hi), j_r[25:0], 2'h0} && !fetch_addr_error;
   endproperty
   a_region_target: assert property (p_region_target) else $error("bad region");
   property p_reg_target;
      redirect && j_r[31:26] == 6'h00 |->
         target == s_r && fetch_addr_error == (s_r[1:0] != 2'h0);
   endproperty
   a_reg_target: assert property (p_reg_target) else $error("bad reg target");
   property p_hint;
      take && instr[31:26] == 6'h00 && instr[10:6] != 5'h00 |=> !busy && !link_we;
   endproperty
   a_hint: assert property (p_hint) else $error("hint not ignored");
   property p_mode;
      redirect |-> instruction_set_select == 2'h0;
   endproperty
   a_mode: assert property (p_mode) else $error("mode changed");
endmodule : jtl_chk

// ### jtl_device.sv
module jtl_device #(
   parameter bit HAS_COMPRESSED = 1'b0
) (
   input wire logic CLK,
   input wire logic RST,
   jtl_if.device LNK,
   output logic [31:0] JUMPS_DONE
);
   jtl_pkg::jtl_state_e state_r, state_nxt;
   logic [31:0] target_r;
   logic [1:0] isa_r;
   logic fault_r;
   logic redirect_r;
   logic link_we_r;
   logic [4:0] link_sel_r;
   logic [31:0] link_value_r;
   logic [31:0] count_r;

   ////////////////////////////////////////////////////////////////////////////
   wire [5:0] opc = LNK.instr[jtl_pkg::OPC_MSB:jtl_pkg::OPC_LSB];
   wire [5:0] fn = LNK.instr[5:0];
   wire [4:0] rs = LNK.instr[jtl_pkg::RS_LSB +: 5];
   wire [4:0] rd = LNK.instr[jtl_pkg::RD_LSB +: 5];
   wire [4:0] hint = LNK.instr[jtl_pkg::HINT_LSB +: 5];
   wire is_special = opc == jtl_pkg::OP_SPECIAL;
   wire hint_ok = hint == jtl_pkg::HINT_DEFAULT;
   wire is_rj = is_special && fn == jtl_pkg::FN_REG_JUMP && hint_ok;
   wire is_rl = is_special && fn == jtl_pkg::FN_REG_LINK && hint_ok;
   wire is_aj = opc == jtl_pkg::OP_REGION_JUMP;
   wire is_al = opc == jtl_pkg::OP_REGION_LINK;
   wire take = LNK.instr_valid && state_r == jtl_pkg::JTL_IDLE
               && (is_rj || is_rl || is_aj || is_al);
   wire [31:0] slot_pc = LNK.instr_pc + jtl_pkg::SLOT_OFFSET;
   wire [31:0] region_tgt = {slot_pc[31:jtl_pkg::REGION_LSB], LNK.instr[25:0], 2'b00};
   wire [31:0] src = LNK.src_value;
   wire [31:0] reg_tgt = HAS_COMPRESSED ? {src[31:1], 1'b0} : src;
   wire reg_fault = HAS_COMPRESSED ? (!src[0] && src[1]) : (src[1:0] != 2'b00);
   wire is_reg = is_rj || is_rl;
   assign LNK.src_sel = rs;

   ////////////////////////////////////////////////////////////////////////////
   // Slot executes before target
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         jtl_pkg::JTL_IDLE:
         begin
            if (take && !LNK.instr_valid)
               state_nxt = jtl_pkg::JTL_IDLE;
            else if (take)
               state_nxt = jtl_pkg::JTL_SLOT;
         end
         jtl_pkg::JTL_SLOT:
         begin
            if (LNK.instr_valid)
               state_nxt = jtl_pkg::JTL_IDLE;
         end
         default: state_nxt = jtl_pkg::JTL_IDLE;
      endcase
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         state_r <= jtl_pkg::JTL_IDLE;
         target_r <= jtl_pkg::RESET_PC;
         isa_r <= 2'b00;
         fault_r <= 1'b0;
         redirect_r <= 1'b0;
         link_we_r <= 1'b0;
         link_sel_r <= 5'h00;
         link_value_r <= 32'h0000_0000;
         count_r <= 32'h0000_0000;
      end
      else
      begin
         state_r <= state_nxt;
         // Redirect pulses once the slot has been accepted
         redirect_r <= state_r == jtl_pkg::JTL_SLOT && LNK.instr_valid;
         link_we_r <= take && (is_al || is_rl);
         if (take)
         begin
            target_r <= is_reg ? reg_tgt : region_tgt;
            fault_r <= is_reg && reg_fault;
            if (is_reg && HAS_COMPRESSED)
               isa_r <= {1'b0, src[0]};
            link_sel_r <= is_al ? jtl_pkg::LINK_REG : rd;
            link_value_r <= LNK.instr_pc + jtl_pkg::LINK_OFFSET;
            count_r <= count_r + 32'h0000_0001;
         end
      end
   end

   assign LNK.redirect = redirect_r;
   assign LNK.target = target_r;
   assign LNK.instruction_set_select = isa_r;
   // Fault is held from the cycle after the jump is taken until the next jump; the host samples it with the redirect
   assign LNK.fetch_addr_error = fault_r;
   assign LNK.link_we = link_we_r;
   assign LNK.link_sel = link_sel_r;
   assign LNK.link_value = link_value_r;
   assign LNK.busy = state_r == jtl_pkg::JTL_SLOT;
   assign JUMPS_DONE = count_r;
endmodule : jtl_device

// ### jtl_host.sv
module jtl_host (
   input wire logic CLK,
   input wire logic RST,
   jtl_if.host LNK,
   input wire logic ISSUE,
   input wire logic [31:0] INSTR,
   input wire logic [31:0] PC,
   input wire logic [31:0] REG_VALUE,
   output logic [4:0] REG_SEL,
   output logic REDIRECT,
   output logic [31:0] TARGET,
   output logic FAULT,
   output logic [1:0] MODE,
   output logic LINK_WE,
   output logic [4:0] LINK_SEL,
   output logic [31:0] LINK_VALUE
);
   wire [4:0] rs = INSTR[jtl_pkg::RS_LSB +: 5];
   wire [4:0] rd = INSTR[jtl_pkg::RD_LSB +: 5];
   wire is_rl = INSTR[31:26] == jtl_pkg::OP_SPECIAL && INSTR[5:0] == jtl_pkg::FN_REG_LINK;
   wire [4:0] rd_fix = (is_rl && rd == 5'h00) ? jtl_pkg::LINK_REG : rd;
   wire bad = is_rl && rd_fix == rs;
   wire slot_bad = LNK.busy && (INSTR[31:26] == jtl_pkg::OP_REGION_JUMP
      || INSTR[31:26] == jtl_pkg::OP_REGION_LINK
      || (INSTR[31:26] == jtl_pkg::OP_SPECIAL && INSTR[5:1] == 5'h04));
   wire [31:0] instr_fix = {INSTR[31:16], rd_fix, INSTR[10:0]};

   assign LNK.instr_valid = ISSUE && !bad && !slot_bad;
   assign LNK.instr = instr_fix;
   assign LNK.instr_pc = PC;
   assign LNK.src_value = REG_VALUE;

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         REG_SEL <= 5'h00;
         REDIRECT <= 1'b0;
         TARGET <= 32'h0000_0000;
         FAULT <= 1'b0;
         MODE <= 2'b00;
         LINK_WE <= 1'b0;
         LINK_SEL <= 5'h00;
         LINK_VALUE <= 32'h0000_0000;
      end
      else
      begin
         REG_SEL <= LNK.src_sel;
         REDIRECT <= LNK.redirect;
         TARGET <= LNK.target;
         FAULT <= LNK.redirect && LNK.fetch_addr_error;
         MODE <= LNK.instruction_set_select;
         LINK_WE <= LNK.link_we;
         LINK_SEL <= LNK.link_sel;
         LINK_VALUE <= LNK.link_value;
      end
   end
endmodule : jtl_host

// ### jtl_if.sv
interface jtl_if;
   logic instr_valid;
   logic [31:0] instr;
   logic [31:0] instr_pc;
   logic [31:0] src_value;
   logic [4:0] src_sel;
   logic redirect;
   logic [31:0] target;
   logic [1:0] instruction_set_select;
   logic fetch_addr_error;
   logic link_we;
   logic [4:0] link_sel;
   logic [31:0] link_value;
   logic busy;
   modport device (input instr_valid, input instr, input instr_pc, input src_value,
                   output src_sel, output redirect, output target,
                   output instruction_set_select, output fetch_addr_error,
                   output link_we, output link_sel, output link_value, output busy);
   modport host (output instr_valid, output instr, output instr_pc, output src_value,
                 input src_sel, input redirect, input target,
                 input instruction_set_select, input fetch_addr_error,
                 input link_we, input link_sel, input link_value, input busy);
endinterface : jtl_if

// ### jtl_pkg.sv
// Functional notes
// - Region target low bits: index shifted two
// - Upper target bits from delay-slot address
// - Execute delay slot before the target
// - Region link jump writes PC+8 to 31
// - Register link jump writes PC+8 to rd
// - Omitted destination encodes register 31
// - Plain mode: low two bits fault at fetch
// - Compressed: mode from bit0, target bit0 cleared
// - Compressed: bit0 zero, bit1 one faults
// - Hint zero means ordinary execution
// - Software keeps source and destination distinct
// - No control transfer in delay slot
package jtl_pkg;
   localparam int XLEN = 32;
   localparam logic [5:0] OP_SPECIAL = 6'h00;
   localparam logic [5:0] OP_REGION_JUMP = 6'h02;
   localparam logic [5:0] OP_REGION_LINK = 6'h03;
   localparam logic [5:0] FN_REG_JUMP = 6'h08;
   localparam logic [5:0] FN_REG_LINK = 6'h09;
   localparam logic [4:0] LINK_REG = 5'h1F;
   localparam logic [4:0] HINT_DEFAULT = 5'h00;
   localparam logic [31:0] LINK_OFFSET = 32'h0000_0008;
   localparam logic [31:0] SLOT_OFFSET = 32'h0000_0004;
   localparam int REGION_LSB = 28;
   localparam logic [31:0] RESET_PC = 32'h0000_0000;
   localparam int OPC_MSB = 31;
   localparam int OPC_LSB = 26;
   localparam int RS_LSB = 21;
   localparam int RD_LSB = 11;
   localparam int HINT_LSB = 6;
   typedef enum logic [1:0]
   {
      JTL_IDLE = 2'b00,
      JTL_SLOT = 2'b01
   } jtl_state_e;
endpackage : jtl_pkg

// ### testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic issue = 1'b0;
   logic [31:0] ins = 32'h0;
   logic [31:0] pc = 32'h0;
   logic [31:0] rv = 32'h0;
   logic redir, flt, lwe;
   logic [4:0] lsel;
   logic [31:0] tgt, lval;
   int fails = 0;
   int n_tests = 0;
   logic [36:0] q_link [$];
   logic [36:0] q_tgt [$];
   logic [36:0] q_cmp [$];
   logic [1:0] mode_c = 2'b00;
   logic [31:0] jumps;
   jtl_if lnk ();
   jtl_if lnk_c ();
   jtl_device jtl_device_inst (.CLK(clk), .RST(rst), .LNK(lnk), .JUMPS_DONE(jumps));
   // Compressed variant sees the same issue stream, so its redirect side can be compared too
   assign lnk_c.instr_valid = lnk.instr_valid;
   assign lnk_c.instr = lnk.instr;
   assign lnk_c.instr_pc = lnk.instr_pc;
   assign lnk_c.src_value = lnk.src_value;
   jtl_device #(.HAS_COMPRESSED(1'b1)) jtl_device_c_inst (.CLK(clk), .RST(rst), .LNK(lnk_c),
      .JUMPS_DONE());
   wire [36:0] cmp_out = {2'h0, lnk_c.fetch_addr_error, lnk_c.instruction_set_select,
      lnk_c.target};
   jtl_host jtl_host_inst (.CLK(clk), .RST(rst), .LNK(lnk), .ISSUE(issue), .INSTR(ins),
      .PC(pc), .REG_VALUE(rv), .REG_SEL(), .REDIRECT(redir), .TARGET(tgt), .FAULT(flt),
      .MODE(), .LINK_WE(lwe), .LINK_SEL(lsel), .LINK_VALUE(lval));
   jtl_chk jtl_chk_inst (.CLK(clk), .RST(rst), .instr_valid(lnk.instr_valid),
      .instr(lnk.instr), .instr_pc(lnk.instr_pc), .src_value(lnk.src_value),
      .redirect(lnk.redirect), .target(lnk.target), .busy(lnk.busy),
      .instruction_set_select(lnk.instruction_set_select), .link_we(lnk.link_we),
      .fetch_addr_error(lnk.fetch_addr_error), .link_sel(lnk.link_sel),
      .link_value(lnk.link_value));
   initial
   begin
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("compares=%0d mismatches=%0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [36:0] got, input logic [36:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Empty queue gives an unknown note, so a stray result never matches
   always @(posedge clk)
   begin
      if (lwe === 1'b1)
         chk({lsel, lval}, q_link.size() ? q_link.pop_front() : 'x);
      if (redir === 1'b1)
         chk({4'h0, flt, tgt}, q_tgt.size() ? q_tgt.pop_front() : 'x);
      if (lnk_c.redirect === 1'b1)
         chk(cmp_out, q_cmp.size() ? q_cmp.pop_front() : 'x);
   end
   function automatic logic [31:0] mk(input int k, input logic [31:0] v);
      // Even destination never equals source 3
      mk = k < 2 ? {k == 1 ? 6'h03 : 6'h02, v[25:0]} :
         {11'h003, 5'h00, v[15:12], 1'b0, 5'h00, k == 3 ? 6'h09 : 6'h08};
   endfunction : mk
   task automatic run(input logic [31:0] i, input logic [31:0] p, input logic [31:0] r);
      logic [31:0] p4;
      p4 = p + 32'h4;
      if (i[31:27] == 5'h01)
      begin
         q_tgt.push_back({5'h00, p4[31:28], i[25:0], 2'h0});
         q_cmp.push_back({3'h0, mode_c, p4[31:28], i[25:0], 2'h0});
      end
      else if (i[10:6] == 5'h00)
      begin
         q_tgt.push_back({4'h0, r[1:0] != 2'h0, r});
         // Compressed: bit 0 picks the mode and is cleared, only pattern 10 faults
         q_cmp.push_back({2'h0, !r[0] && r[1], 1'b0, r[0], r[31:1], 1'b0});
         mode_c = {1'b0, r[0]};
      end
      if (i[31:26] == 6'h03)
         q_link.push_back({5'h1F, p + 32'h8});
      else if (i[31:26] == 6'h00 && i[5:0] == 6'h09 && i[10:6] == 5'h00)
         q_link.push_back({i[15:11] == 5'h00 ? 5'h1F : i[15:11], p + 32'h8});
      @(posedge clk) #1;
      issue = 1'b1;
      ins = i;
      pc = p;
      rv = r;
      @(posedge clk) #1;
      ins = 32'h0;
      pc = p4;
      rv = ~r;
      @(posedge clk) #1;
      issue = 1'b0;
      for (int k = 0; k < 20 && (q_link.size() || q_tgt.size() || q_cmp.size()); k++)
         @(posedge clk);
      if (q_link.size() || q_tgt.size() || q_cmp.size())
      begin
         fails++;
         end_of_test();
      end
      $display("test done pc=%h", p);
   endtask : run
   initial
   begin
      void'($urandom(18));
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
      for (int n = 0; n < 16; n++)
         run(mk(n % 4, $urandom()), n == 1 ? 32'h0FFF_FFFC : $urandom() & 32'hFFFF_FFFC,
            $urandom());
      run(mk(3, 32'h0), 32'h0000_0100, 32'h0000_0202);
      run(mk(2, 32'h0) | 32'h0000_0100, 32'h0000_0040, 32'h0000_0080);
      // Seventeen jumps accepted, the nonzero-hint one refused
      chk({5'h00, jumps}, 37'h00_0000_0011);
      end_of_test();
   end
endmodule : testbench
